// ==== design/usb_ep_descriptor_engine.sv ====
/*
  Endpoint response decoding and packet-buffer descriptor handling for a
  full-speed device controller, with the shared packet memory in flip-flops.
  Assumes a transaction engine that presents decoded tokens, drains IN bytes
  with a ready handshake, delivers OUT/SETUP bytes, and sends the handshakes.
*/
// Implementation choices: the register offsets and the plain strobed port.
// Functional notes
// - receive state 00 ignores host data requests, no handshake given.
// - receive state 01 answers every receive request with STALL.
// - receive state 10 answers every receive request with NAK.
// - receive state 11 accepts OUT or SETUP data into the receive buffer.
// - transmit state 00 ignores every IN request.
// - transmit state 01 answers every IN request with STALL.
// - transmit state 10 answers every IN request with NAK.
// - transmit state 11 sends transmit buffer data on IN.
// - type 00 bulk, 01 control, 10 isochronous, 11 interrupt.
// - kind means double buffer for bulk, status-out for control, else nothing.
// - descriptor n at base plus 8n locally, base plus 16n for software.
// - IN data start is transmit address bits 15:1, bit 0 forced zero.
// - IN packet length is transmit count bits 9:0.
// - double-buffered and isochronous use two count sets, bits 9:0 and 25:16.
// - OUT/SETUP data stored from receive address bits 15:1, halfword aligned.
// - received byte count written to bits 9:0; software cannot write it.
// - receive size from block quantity 14:10 and block granule bit 15.
// - small granule size is twice quantity; quantity zero not allowed.
// - large granule size is 32 times quantity plus one; 10000 up reserved.
// - double-buffered receive uses second set at 25:16, 30:26 and 31.
// - state fields ignore written zeros and flip on written ones.
`timescale 1ns/1ps
module usb_ep_descriptor_engine (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [usb_ep_pkg::REG_ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire usb_ep_pkg::token_t token_i,
  output usb_ep_pkg::reply_t reply_o,
  input wire usb_ep_pkg::byte_beat_t rx_byte_i,
  output usb_ep_pkg::byte_beat_t tx_byte_o,
  input wire logic tx_ready_i,
  output logic busy_o
);

  // ==========================================================================
  // Declarations
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RX = 2'b01,
    ST_RX_DONE = 2'b11,
    ST_TX = 2'b10
  } eng_state_t;

  eng_state_t state_reg;
  usb_ep_pkg::ep_ctrl_t ep_ctrl_reg [usb_ep_pkg::NUM_EP];
  logic [31:0] mem_reg [usb_ep_pkg::MEM_WORDS];
  logic [15:0] table_base_reg;
  logic [2:0] cur_ep_reg;
  logic [15:0] ptr_reg;
  logic [usb_ep_pkg::COUNT_W-1:0] remain_reg;
  logic [usb_ep_pkg::COUNT_W-1:0] rcv_cnt_reg;
  logic [usb_ep_pkg::SIZE_W-1:0] limit_reg;
  logic set_sel_reg;
  logic setup_reg;
  logic [7:0] tx_data_reg;
  logic [31:0] rdata_reg;
  usb_ep_pkg::reply_t reply_reg;

  logic hit;
  logic [2:0] hit_idx;
  logic [2:0] ep_idx;
  usb_ep_pkg::ep_ctrl_t cur_ctrl;
  logic dbl;
  logic use_second;
  logic [6:0] base_idx;
  logic [31:0] tx_cnt_word;
  logic [31:0] rx_cnt_word;
  logic [15:0] tx_start;
  logic [15:0] rx_start;
  logic [usb_ep_pkg::COUNT_W-1:0] tx_len;
  logic [usb_ep_pkg::SIZE_W-1:0] size_first;
  logic [usb_ep_pkg::SIZE_W-1:0] size_second;
  usb_ep_pkg::reply_code_t tx_code;
  usb_ep_pkg::reply_code_t rx_code;
  logic token_take;
  logic tx_step;
  logic rx_step;
  logic hw_swap;
  logic [15:0] rx_wr_addr;
  logic [31:0] rx_done_word;
  logic ctrl_sel;
  logic [2:0] ctrl_idx;
  logic mem_sel;
  logic [6:0] mem_idx;
  logic [6:0] mem_off;
  logic [31:0] sw_keep_mask;

  // ==========================================================================
  // Helpers
  function automatic logic [6:0] desc_at(input logic [6:0] base, input logic [2:0] ep, input logic [1:0] entry);
    desc_at = 7'(base + {2'h0, ep, entry});
  endfunction

  function automatic logic [7:0] byte_at(input logic [15:0] a);
    logic [31:0] w;
    w = mem_reg[a[7:1]];
    byte_at = a[0] ? w[15:8] : w[7:0];
  endfunction

  function automatic logic [31:0] pack_ctrl(input usb_ep_pkg::ep_ctrl_t c);
    logic [31:0] v;
    v = 32'h0;
    v[usb_ep_pkg::EP_ADDR_LSB +: 4] = c.ep_addr;
    v[usb_ep_pkg::TX_STATE_LSB +: 2] = c.tx_state;
    v[usb_ep_pkg::KIND_BIT] = c.kind;
    v[usb_ep_pkg::TYPE_LSB +: 2] = c.ep_type;
    v[usb_ep_pkg::RX_STATE_LSB +: 2] = c.rx_state;
    v[usb_ep_pkg::BUF_SEL_BIT] = c.buf_sel;
    pack_ctrl = v;
  endfunction

  // ==========================================================================
  // Endpoint lookup and descriptor fetch
  // Lowest-numbered endpoint wins if software programs duplicate addresses
  always_comb begin
    hit = 1'b0;
    hit_idx = 3'h0;
    for (int i = usb_ep_pkg::NUM_EP - 1; i >= 0; i--) begin
      if (ep_ctrl_reg[i].ep_addr == token_i.ep_addr) begin
        hit = 1'b1;
        hit_idx = 3'(i);
      end
    end
  end

  assign ep_idx = (state_reg == ST_IDLE) ? hit_idx : cur_ep_reg;
  assign cur_ctrl = ep_ctrl_reg[ep_idx];
  assign base_idx = table_base_reg[7:1];
  // Kind only means double buffering on bulk; isochronous always has two sets
  assign dbl = (cur_ctrl.ep_type == usb_ep_pkg::EPT_BULK && cur_ctrl.kind) ||
               (cur_ctrl.ep_type == usb_ep_pkg::EPT_ISO);
  assign use_second = dbl && cur_ctrl.buf_sel;

  assign tx_cnt_word = mem_reg[desc_at(base_idx, ep_idx, usb_ep_pkg::DESC_TX_CNT)];
  assign rx_cnt_word = mem_reg[desc_at(base_idx, ep_idx, usb_ep_pkg::DESC_RX_CNT)];
  assign tx_len = use_second ? tx_cnt_word[usb_ep_pkg::CNT_SECOND_LSB +: 10]
                             : tx_cnt_word[usb_ep_pkg::CNT_FIRST_LSB +: 10];

  // The second buffer of a double-buffered endpoint sits at the other address entry
  always_comb begin
    logic [31:0] a_tx;
    logic [31:0] a_rx;
    a_tx = mem_reg[desc_at(base_idx, ep_idx, usb_ep_pkg::DESC_TX_ADDR)];
    a_rx = mem_reg[desc_at(base_idx, ep_idx, usb_ep_pkg::DESC_RX_ADDR)];
    tx_start = use_second ? {a_rx[15:1], 1'b0} : {a_tx[15:1], 1'b0};
    rx_start = use_second ? {a_tx[15:1], 1'b0} : {a_rx[15:1], 1'b0};
  end

  rx_buffer_size u_size_first (
    .granule_i(rx_cnt_word[usb_ep_pkg::GRANULE_FIRST_BIT]),
    .quantity_i(rx_cnt_word[usb_ep_pkg::QTY_FIRST_LSB +: 5]),
    .size_o(size_first)
  );

  rx_buffer_size u_size_second (
    .granule_i(rx_cnt_word[usb_ep_pkg::GRANULE_SECOND_BIT]),
    .quantity_i(rx_cnt_word[usb_ep_pkg::QTY_SECOND_LSB +: 5]),
    .size_o(size_second)
  );

  ep_state_decode u_tx_decode (
    .state_i(cur_ctrl.tx_state),
    .is_tx_i(1'b1),
    .code_o(tx_code)
  );

  ep_state_decode u_rx_decode (
    .state_i(cur_ctrl.rx_state),
    .is_tx_i(1'b0),
    .code_o(rx_code)
  );

  // ==========================================================================
  // Transaction sequencing
  assign token_take = (state_reg == ST_IDLE) && token_i.valid;
  assign tx_step = (state_reg == ST_TX) && tx_ready_i;
  assign rx_step = (state_reg == ST_RX) && rx_byte_i.valid;
  assign rx_wr_addr = 16'(ptr_reg + {6'h0, rcv_cnt_reg});
  assign hw_swap = (state_reg == ST_RX_DONE || (tx_step && remain_reg == 10'h1) ||
                    (token_take && hit && token_i.kind == usb_ep_pkg::TK_IN &&
                     tx_code == usb_ep_pkg::RC_DATA && tx_len == 10'h0)) && dbl;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (token_take && hit) begin
            if (token_i.kind == usb_ep_pkg::TK_IN) begin
              if (tx_code == usb_ep_pkg::RC_DATA && tx_len != 10'h0) begin
                state_reg <= ST_TX;
              end
            end else if (rx_code == usb_ep_pkg::RC_ACK) begin
              state_reg <= ST_RX;
            end
          end
        end
        ST_RX: begin
          if (rx_step && rx_byte_i.last) begin
            state_reg <= ST_RX_DONE;
          end
        end
        ST_RX_DONE: state_reg <= ST_IDLE;
        ST_TX: begin
          if (tx_step && remain_reg == 10'h1) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur_ep_reg <= 3'h0;
      ptr_reg <= 16'h0;
      remain_reg <= 10'h0;
      rcv_cnt_reg <= 10'h0;
      limit_reg <= 11'h0;
      set_sel_reg <= 1'b0;
      setup_reg <= 1'b0;
      tx_data_reg <= 8'h0;
    end else if (token_take && hit) begin
      cur_ep_reg <= hit_idx;
      set_sel_reg <= use_second;
      setup_reg <= (token_i.kind == usb_ep_pkg::TK_SETUP);
      rcv_cnt_reg <= 10'h0;
      remain_reg <= tx_len;
      limit_reg <= use_second ? size_second : size_first;
      if (token_i.kind == usb_ep_pkg::TK_IN) begin
        ptr_reg <= tx_start;
        tx_data_reg <= byte_at(tx_start);
      end else begin
        ptr_reg <= rx_start;
      end
    end else if (tx_step) begin
      ptr_reg <= 16'(ptr_reg + 16'h1);
      remain_reg <= 10'(remain_reg - 10'h1);
      tx_data_reg <= byte_at(16'(ptr_reg + 16'h1));
    end else if (rx_step && rcv_cnt_reg != usb_ep_pkg::COUNT_MAX) begin
      rcv_cnt_reg <= 10'(rcv_cnt_reg + 10'h1);
    end
  end

  // Status-out control endpoints refuse a non-empty status stage
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reply_reg <= '0;
    end else begin
      reply_reg <= '0;
      if (token_take) begin
        if (!hit) begin
          reply_reg <= '{valid: 1'b1, code: usb_ep_pkg::RC_SILENT, count: 10'h0};
        end else if (token_i.kind == usb_ep_pkg::TK_IN) begin
          reply_reg <= '{valid: 1'b1, code: tx_code, count: tx_len};
        end else if (rx_code != usb_ep_pkg::RC_ACK) begin
          reply_reg <= '{valid: 1'b1, code: rx_code, count: 10'h0};
        end
      end else if (state_reg == ST_RX_DONE) begin
        reply_reg.valid <= 1'b1;
        reply_reg.count <= rcv_cnt_reg;
        if (cur_ctrl.ep_type == usb_ep_pkg::EPT_CONTROL && cur_ctrl.kind && !setup_reg &&
            rcv_cnt_reg != 10'h0) begin
          reply_reg.code <= usb_ep_pkg::RC_STALL;
        end else begin
          reply_reg.code <= usb_ep_pkg::RC_ACK;
        end
      end
    end
  end

  always_comb begin
    rx_done_word = rx_cnt_word;
    if (set_sel_reg) begin
      rx_done_word[usb_ep_pkg::CNT_SECOND_LSB +: 10] = rcv_cnt_reg;
    end else begin
      rx_done_word[usb_ep_pkg::CNT_FIRST_LSB +: 10] = rcv_cnt_reg;
    end
  end

  // ==========================================================================
  // Register port decode
  assign ctrl_sel = reg_addr_i >= usb_ep_pkg::EP_CTRL_OFS && reg_addr_i < usb_ep_pkg::EP_CTRL_END;
  assign ctrl_idx = reg_addr_i[4:2];
  assign mem_sel = reg_addr_i >= usb_ep_pkg::MEM_WIN_OFS;
  assign mem_idx = reg_addr_i[8:2];
  assign mem_off = 7'(mem_idx - base_idx);
  // Received counts belong to hardware; software writes leave them alone
  assign sw_keep_mask = (mem_off < usb_ep_pkg::DESC_TABLE_WORDS && mem_off[1:0] == usb_ep_pkg::DESC_RX_CNT) ?
                        usb_ep_pkg::RX_COUNT_MASK : 32'h0;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < usb_ep_pkg::NUM_EP; i++) begin
        ep_ctrl_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < usb_ep_pkg::NUM_EP; i++) begin
        if (reg_wr_i && ctrl_sel && ctrl_idx == 3'(i)) begin
          ep_ctrl_reg[i].ep_addr <= reg_wdata_i[usb_ep_pkg::EP_ADDR_LSB +: 4];
          ep_ctrl_reg[i].kind <= reg_wdata_i[usb_ep_pkg::KIND_BIT];
          ep_ctrl_reg[i].ep_type <= usb_ep_pkg::ep_type_t'(reg_wdata_i[usb_ep_pkg::TYPE_LSB +: 2]);
          ep_ctrl_reg[i].tx_state <= usb_ep_pkg::resp_state_t'(ep_ctrl_reg[i].tx_state ^
                                     reg_wdata_i[usb_ep_pkg::TX_STATE_LSB +: 2]);
          ep_ctrl_reg[i].rx_state <= usb_ep_pkg::resp_state_t'(ep_ctrl_reg[i].rx_state ^
                                     reg_wdata_i[usb_ep_pkg::RX_STATE_LSB +: 2]);
        end
        // A software flip and a hardware swap in one cycle both take effect
        ep_ctrl_reg[i].buf_sel <= ep_ctrl_reg[i].buf_sel ^
                                  (reg_wr_i && ctrl_sel && ctrl_idx == 3'(i) && reg_wdata_i[usb_ep_pkg::BUF_SEL_BIT]) ^
                                  (hw_swap && ep_idx == 3'(i));
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      table_base_reg <= usb_ep_pkg::TABLE_BASE_RESET;
    end else if (reg_wr_i && reg_addr_i == usb_ep_pkg::TABLE_BASE_OFS) begin
      table_base_reg <= {reg_wdata_i[15:3], 3'h0};
    end
  end

  // Engine writes land after software writes so the engine wins a clash
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < usb_ep_pkg::MEM_WORDS; i++) begin
        mem_reg[i] <= usb_ep_pkg::MEM_RESET;
      end
    end else begin
      if (reg_wr_i && mem_sel) begin
        mem_reg[mem_idx] <= (reg_wdata_i & ~sw_keep_mask) | (mem_reg[mem_idx] & sw_keep_mask);
      end
      if (rx_step && {1'b0, rcv_cnt_reg} < limit_reg) begin
        if (rx_wr_addr[0]) begin
          mem_reg[rx_wr_addr[7:1]][15:8] <= rx_byte_i.data;
        end else begin
          mem_reg[rx_wr_addr[7:1]][7:0] <= rx_byte_i.data;
        end
      end
      if (state_reg == ST_RX_DONE) begin
        mem_reg[desc_at(base_idx, cur_ep_reg, usb_ep_pkg::DESC_RX_CNT)] <= rx_done_word;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_reg <= 32'h0;
    end else if (reg_rd_i) begin
      if (ctrl_sel) begin
        rdata_reg <= pack_ctrl(ep_ctrl_reg[ctrl_idx]);
      end else if (reg_addr_i == usb_ep_pkg::TABLE_BASE_OFS) begin
        rdata_reg <= {16'h0, table_base_reg};
      end else if (reg_addr_i == usb_ep_pkg::STATUS_OFS) begin
        rdata_reg <= {6'h0, rcv_cnt_reg, 11'h0, cur_ep_reg, state_reg};
      end else if (mem_sel) begin
        rdata_reg <= mem_reg[mem_idx];
      end else begin
        rdata_reg <= 32'h0;
      end
    end else begin
      rdata_reg <= 32'h0;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata_o = rdata_reg;
  assign reply_o = reply_reg;
  assign tx_byte_o = '{valid: state_reg == ST_TX, last: remain_reg == 10'h1, data: tx_data_reg};
  assign busy_o = state_reg != ST_IDLE;

endmodule // usb_ep_descriptor_engine

// ==== design/usb_ep_pkg.sv ====
/*
  Shared constants and types for the endpoint descriptor engine: register
  map, control field positions, descriptor layout, count-word fields and
  the token, reply and byte-stream carriers.
  Assumes a single 250 MHz clock domain and one owner of every carrier.
*/
package usb_ep_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_EP = 8;
  localparam int MEM_WORDS = 128;
  localparam int MEM_IDX_W = 7;
  localparam int REG_ADDR_W = 10;
  localparam int COUNT_W = 10;
  localparam int SIZE_W = 11;

  // ==========================================================================
  // Register port map (byte offsets)
  localparam logic [9:0] EP_CTRL_OFS = 10'h000;
  localparam logic [9:0] EP_CTRL_END = 10'h020;
  localparam logic [9:0] TABLE_BASE_OFS = 10'h020;
  localparam logic [9:0] STATUS_OFS = 10'h024;
  localparam logic [9:0] MEM_WIN_OFS = 10'h200;

  // ==========================================================================
  // Endpoint control field positions
  localparam int EP_ADDR_LSB = 0;
  localparam int TX_STATE_LSB = 4;
  localparam int KIND_BIT = 8;
  localparam int TYPE_LSB = 9;
  localparam int RX_STATE_LSB = 12;
  localparam int BUF_SEL_BIT = 14;

  // ==========================================================================
  // Descriptor layout: four words per endpoint in the packet memory
  localparam logic [1:0] DESC_TX_ADDR = 2'h0;
  localparam logic [1:0] DESC_TX_CNT = 2'h1;
  localparam logic [1:0] DESC_RX_ADDR = 2'h2;
  localparam logic [1:0] DESC_RX_CNT = 2'h3;
  localparam logic [6:0] DESC_TABLE_WORDS = 7'h20;
  localparam int CNT_FIRST_LSB = 0;
  localparam int CNT_SECOND_LSB = 16;
  localparam int QTY_FIRST_LSB = 10;
  localparam int QTY_SECOND_LSB = 26;
  localparam int GRANULE_FIRST_BIT = 15;
  localparam int GRANULE_SECOND_BIT = 31;
  localparam logic [31:0] RX_COUNT_MASK = 32'h03ff_03ff;

  // ==========================================================================
  // Reset values and receive count limit
  localparam logic [15:0] TABLE_BASE_RESET = 16'h0000;
  localparam logic [31:0] MEM_RESET = 32'h0000_0000;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 10'h3ff;

  // ==========================================================================
  // Encodings
  typedef enum logic [1:0] {
    RS_DISABLED = 2'h0,
    RS_STALL = 2'h1,
    RS_NAK = 2'h2,
    RS_VALID = 2'h3
  } resp_state_t;

  typedef enum logic [1:0] {
    EPT_BULK = 2'h0,
    EPT_CONTROL = 2'h1,
    EPT_ISO = 2'h2,
    EPT_INTERRUPT = 2'h3
  } ep_type_t;

  typedef enum logic [1:0] {
    TK_OUT = 2'h0,
    TK_IN = 2'h1,
    TK_SETUP = 2'h2
  } token_kind_t;

  typedef enum logic [2:0] {
    RC_SILENT = 3'h0,
    RC_STALL = 3'h1,
    RC_NAK = 3'h2,
    RC_DATA = 3'h3,
    RC_ACK = 3'h4
  } reply_code_t;

  typedef struct packed {
    logic buf_sel;
    resp_state_t rx_state;
    ep_type_t ep_type;
    logic kind;
    resp_state_t tx_state;
    logic [3:0] ep_addr;
  } ep_ctrl_t;

  typedef struct packed {
    logic valid;
    token_kind_t kind;
    logic [3:0] ep_addr;
  } token_t;

  typedef struct packed {
    logic valid;
    reply_code_t code;
    logic [COUNT_W-1:0] count;
  } reply_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } byte_beat_t;

endpackage

// ==== design/ep_state_decode.sv ====
/*
  Turns a two-bit response-state field into the handshake to give.
  Assumes the caller says whether the field is the transmit or receive one.
*/
`timescale 1ns/1ps
module ep_state_decode (
  input wire usb_ep_pkg::resp_state_t state_i,
  input wire logic is_tx_i,
  output usb_ep_pkg::reply_code_t code_o
);

  always_comb begin
    unique case (state_i)
      usb_ep_pkg::RS_DISABLED: code_o = usb_ep_pkg::RC_SILENT;
      usb_ep_pkg::RS_STALL: code_o = usb_ep_pkg::RC_STALL;
      usb_ep_pkg::RS_NAK: code_o = usb_ep_pkg::RC_NAK;
      usb_ep_pkg::RS_VALID: code_o = is_tx_i ? usb_ep_pkg::RC_DATA : usb_ep_pkg::RC_ACK;
    endcase
  end

endmodule // ep_state_decode

// ==== design/rx_buffer_size.sv ====
/*
  Receive buffer size in bytes from one block-granule bit and a five-bit
  block quantity. Assumes software keeps off the disallowed codes.
*/
`timescale 1ns/1ps
module rx_buffer_size (
  input wire logic granule_i,
  input wire logic [4:0] quantity_i,
  output logic [usb_ep_pkg::SIZE_W-1:0] size_o
);

  // Large granule: 32 * (quantity + 1); small granule: 2 * quantity
  always_comb begin
    if (granule_i) begin
      size_o = {quantity_i + 5'h1, 5'h0} == 10'h0 ? 11'h400 : {1'b0, quantity_i + 5'h1, 5'h0};
    end else begin
      size_o = {5'h0, quantity_i, 1'b0};
    end
  end

endmodule // rx_buffer_size

// ==== verification/usb_ep_descriptor_engine_assertions.sv ====
/*
  Port checker for the endpoint descriptor engine: reply timing and IN stream.
  Assumes it is bound to usb_ep_descriptor_engine, one clock domain.
*/
`timescale 1ns/1ps
module usb_ep_descriptor_engine_checker (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire usb_ep_pkg::token_t token_i,
  input wire usb_ep_pkg::reply_t reply_o,
  input wire usb_ep_pkg::byte_beat_t rx_byte_i,
  input wire usb_ep_pkg::byte_beat_t tx_byte_o,
  input wire logic tx_ready_i,
  input wire logic busy_o
);
  // ==========
  // Replies and IN stream
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  AST_IN_PROMPT: assert property (
    token_i.valid && !busy_o && token_i.kind == usb_ep_pkg::TK_IN |=> reply_o.valid) else $error("IN not answered");
  AST_IN_NO_DATA: assert property (
    reply_o.valid && reply_o.code != usb_ep_pkg::RC_DATA && $past(token_i.valid)
    && $past(token_i.kind) == usb_ep_pkg::TK_IN |-> !busy_o && !tx_byte_o.valid) else $error("refused IN sends");
  AST_DATA_START: assert property (
    reply_o.valid && reply_o.code == usb_ep_pkg::RC_DATA && reply_o.count != 10'h000
    |-> tx_byte_o.valid && busy_o) else $error("DATA without bytes");
  AST_DATA_CAUSE: assert property (
    reply_o.valid && reply_o.code == usb_ep_pkg::RC_DATA
    |-> $past(token_i.valid && token_i.kind == usb_ep_pkg::TK_IN)) else $error("DATA without IN");
  AST_ACK_CAUSE: assert property (
    reply_o.valid && reply_o.code == usb_ep_pkg::RC_ACK
    |-> $past(rx_byte_i.valid && rx_byte_i.last, 2)) else $error("ACK not after last byte");
  AST_TX_HOLD: assert property (
    tx_byte_o.valid && !tx_ready_i |=> tx_byte_o.valid && $stable(tx_byte_o.data)) else $error("IN byte lost");
  AST_REFUSE_IDLE: assert property (
    reply_o.valid && reply_o.code inside {usb_ep_pkg::RC_STALL, usb_ep_pkg::RC_NAK}
    |-> !busy_o) else $error("busy after refusal");
  AST_SILENT_IDLE: assert property (
    reply_o.valid && reply_o.code == usb_ep_pkg::RC_SILENT |-> !busy_o && !tx_byte_o.valid) else $error("silent busy");
endmodule // usb_ep_descriptor_engine_checker
bind usb_ep_descriptor_engine usb_ep_descriptor_engine_checker checker_i (.mclk_i, .resetn_i, .token_i,
  .reply_o, .rx_byte_i, .tx_byte_o, .tx_ready_i, .busy_o);

// ==== verification/host_link_model.sv ====
/*
  Far-side consumer of IN bytes: ready always, or at random when slow.
  Assumes the bench picks the pace between transfers.
*/
`timescale 1ns/1ps
module host_link_model (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic slow_i,
  output logic tx_ready_o
);
  // ==========
  // Ready pacing, held low in reset so no byte is taken early
  int seed = 59671;
  logic rnd_reg;
  always_ff @(posedge mclk_i) rnd_reg <= 1'($random(seed));
  assign tx_ready_o = resetn_i & (~slow_i | rnd_reg);
endmodule // host_link_model

// ==== verification/test_usb_ep_descriptor_engine.sv ====
/*
  Bench for the descriptor engine: registers, IN and OUT/SETUP transfers.
  Assumes host_link_model and the bound checker compiled before it.
*/
`timescale 1ns/1ps
module test_usb_ep_descriptor_engine;
  logic mclk_i = 0, resetn_i = 0, reg_wr_i = 0, reg_rd_i = 0, tx_ready_i, busy_o, slow = 0;
  logic [9:0] reg_addr_i = 0;
  logic [31:0] reg_wdata_i = 0, reg_rdata_o, d;
  usb_ep_pkg::token_t token_i = '0;
  usb_ep_pkg::reply_t reply_o, rep;
  usb_ep_pkg::byte_beat_t rx_byte_i = '0, tx_byte_o;
  logic [31:0] mem [16];
  logic [7:0] b [64], lb [256] = '{default: 8'h00}, got [$];
  logic [1:0] ts = 0, rs = 0;
  int bad_count = 0, total_checks = 0, seed = 59671, n, q, g, sz, st, pc = 0, a;
  int probe [4] = '{12, 32, 36, 256};
  localparam int DSC = 10'h3b0;
  usb_ep_descriptor_engine usb_ep_descriptor_engine_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .token_i(token_i), .reply_o(reply_o), .rx_byte_i(rx_byte_i),
    .tx_byte_o(tx_byte_o), .tx_ready_i(tx_ready_i), .busy_o(busy_o));
  host_link_model host_link_model_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .slow_i(slow), .tx_ready_o(tx_ready_i));
  initial forever #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (tx_byte_o.valid === 1'b1 && tx_ready_i === 1'b1) got.push_back(tx_byte_o.data);
  // ==========
  // Helpers
  task results;
    if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    total_checks++;
    if (v !== e) begin
      bad_count++;
      $display("FAIL %s exp %h got %h", nm, e, v);
    end
  endtask
  task wr(input int ad, input logic [31:0] v);
    @(posedge mclk_i);
    reg_addr_i <= 10'(ad);
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input int ad);
    @(posedge mclk_i);
    reg_addr_i <= 10'(ad);
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // Token, optional payload, then a bounded window that catches the reply
  // The reply is watched from the first cycle: a refusal comes back while bytes still flow
  task xfer(input usb_ep_pkg::token_kind_t k, input int nb);
    got.delete();
    rep = '0;
    @(posedge mclk_i);
    token_i <= '{1'b1, k, 4'h5};
    for (int i = 0; i < nb + 64; i++) begin
      @(posedge mclk_i);
      token_i.valid <= 1'b0;
      rx_byte_i <= '{i < nb, i == nb - 1, b[i % 64]};
      #1 if (reply_o.valid === 1'b1) rep = reply_o;
    end
  endtask
  function automatic usb_ep_pkg::reply_code_t exp_code(input int s, input bit tx);
    case (s)
      0: return usb_ep_pkg::RC_SILENT;
      1: return usb_ep_pkg::RC_STALL;
      2: return usb_ep_pkg::RC_NAK;
      default: return tx ? usb_ep_pkg::RC_DATA : usb_ep_pkg::RC_ACK;
    endcase
  endfunction
  initial begin
    #200000 bad_count++;
    results;
  end
  // ==========
  // Sequence
  initial begin
    repeat (10) @(posedge mclk_i);
    resetn_i <= 1'b1;
    foreach (probe[i]) begin
      rd(probe[i]);
      chk("reset/unmapped", 0, d);
    end
    wr(32, 32'hc7);
    rd(32);
    chk("table base", 32'hc0, d);
    for (int w = 0; w < 16; w++) begin
      mem[w] = $random(seed);
      if (w >= 8) wr(32'h200 + 4 * w, mem[w]);
    end
    wr(12, 32'h5);
    for (int s = 0; s < 4; s++) begin
      n = 1 + ($random(seed) & 3);
      wr(DSC, 32'h11);
      wr(DSC + 4, 32'(n) | 32'hfc00);
      wr(12, 32'h5 | 32'(2'(s) ^ ts) << 4);
      ts = 2'(s);
      slow <= s[0];
      xfer(usb_ep_pkg::TK_IN, 0);
      chk("in code", {1'b1, exp_code(s, 1)}, {rep.valid, rep.code});
      chk("in bytes", s == 3 ? n : 0, got.size());
      if (s == 3) chk("in count", n, rep.count);
      for (int k = 0; k < got.size(); k++) chk("in byte", mem[8 + (k >> 1)][8 * (k & 1) +: 8], got[k]);
    end
    for (int s = 0; s < 5; s++) begin
      st = s > 3 ? 3 : s;
      g = s == 4;
      q = g ? 0 : 1 + ($random(seed) & 3);
      sz = g ? 32 * (q + 1) : 2 * q;
      foreach (b[i]) b[i] = 8'($random(seed));
      wr(DSC + 8, 32'h31);
      wr(DSC + 12, 32'h3ff | 32'(g) << 15 | 32'(q) << 10);
      rd(DSC + 12);
      chk("rx count word", 32'(g) << 15 | 32'(q) << 10 | 32'(pc), d);
      wr(12, 32'h5 | 32'(2'(st) ^ rs) << 12);
      rs = 2'(st);
      xfer(s[0] ? usb_ep_pkg::TK_SETUP : usb_ep_pkg::TK_OUT, sz + 2);
      chk("rx code", {1'b1, exp_code(st, 0)}, {rep.valid, rep.code});
      if (st == 3) begin
        chk("rx count", sz + 2, rep.count);
        pc = sz + 2;
        for (int i = 0; i < sz; i++) lb[8'h30 + i] = b[i];
      end
      for (int i = 0; i < sz + 2; i++) begin
        a = 8'h30 + i;
        rd(32'h200 + 4 * (a >> 1));
        chk("rx byte", lb[a], 8'(d >> (8 * (a & 1))));
      end
    end
    // Isochronous with the select flipped: second count, other address entry
    wr(DSC + 4, 32'(n) << 16 | 32'h3);
    wr(12, 32'h4405);
    xfer(usb_ep_pkg::TK_IN, 0);
    chk("dbl bytes", n, got.size());
    chk("dbl count", n, rep.count);
    for (int k = 0; k < got.size(); k++) chk("dbl byte", lb[8'h30 + k], got[k]);
    wr(12, 32'h305);
    xfer(usb_ep_pkg::TK_OUT, 2);
    chk("status out", {usb_ep_pkg::RC_STALL, 10'h2}, {rep.code, rep.count});
    rd(12);
    chk("ctrl", 32'h305 | 32'(ts) << 4 | 32'(rs) << 12, d);
    chk("idle", 0, busy_o);
    results;
  end
endmodule // test_usb_ep_descriptor_engine
